// ---- rtl/fpau_core.sv ----
// arithmetic datapath: accumulator, mq register, transient register, shift counter
`include "fpau_consts.svh"

// Functional notes
// RULE1 - words are 24-bit two's complement fixed point
// RULE2 - except multiply, one operand is in the accumulator beforehand
// RULE3 - add and subtract leave sum or difference in the accumulator
// RULE4 - multiply leaves high product in accumulator, low half in mq
// RULE5 - divide leaves remainder in accumulator; logic ops act on accumulator
// RULE6 - accumulator shifts left or right, circular or end-off
// RULE7 - multiply shifts multiplier right two places, inspecting three low bits
// RULE8 - low partial product bits shift into mq each multiply step
// RULE9 - mq holds low dividend first, then quotient with sign at msb
// RULE10 - accumulator and mq shift together as one 48-bit register
// RULE11 - transient register holds memory operand and index modifier
// RULE12 - transient register carries every word to and from memory; stores here go from acc, mq or counter straight to wdata_q
// RULE13 - a 6-bit counter governs multiply, divide and shift step counts
// RULE14 - scale leaves shift count in counter and writes it to memory
// RULE15 - instruction register feeds decoders and address adder
// RULE16 - add 4.0 us, multiply 12.0 us, divide 22.0 us in total
// RULE17 - counter preloaded, decremented per step, operation ends at zero; scale here counts up from zero until acc bits 23 and 22 differ or FPAU_SCALE_MAX
module fpau_core #(
  parameter int W   = `FPAU_WORD_W,
  parameter int NW  = `FPAU_CNT_W
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               start,
  input  wire fpau_pkg::fpau_op_t op,
  input  wire fpau_pkg::fpau_shift_t shift_mode,
  input  wire logic [NW-1:0]      shift_count,
  input  wire logic [W-1:0]       mem_rdata,
  output logic                    busy,
  output logic                    done,
  output logic                    mem_we,
  output logic [W-1:0]            mem_wdata,
  output logic [W-1:0]            acc,
  output logic [W-1:0]            mq,
  output logic [NW-1:0]           shift_cnt,
  output logic [4:0]              func_code,
  output logic [3:0]              desig,
  output logic [13:0]             eff_addr,
  output logic                    addr_carry
);

  // ========================================
  // state
  fpau_pkg::fpau_state_t state_q;
  fpau_pkg::fpau_op_t    op_q;
  fpau_pkg::fpau_shift_t mode_q;
  logic [W-1:0]          a_q;
  logic [W-1:0]          q_q;
  logic [W-1:0]          d_q;
  logic [W-1:0]          ir_q;
  logic [NW-1:0]         n_q;
  logic                  rem_neg_q;
  logic                  mem_we_q;
  logic [W-1:0]          wdata_q;
  logic                  done_q;
  logic [14:0]           ea_q;
  logic                  pace_load;
  logic                  pace_exp;
  logic [7:0]            pace_cycles;

  // ========================================
  // helpers
  function automatic logic [W+1:0] booth_term(input logic [2:0] bits, input logic [W-1:0] m);
    logic [W+1:0] mx;
    mx = {{2{m[W-1]}}, m};
    unique case (bits)
      3'h1, 3'h2: booth_term = mx;
      3'h3:       booth_term = mx << 1;
      3'h4:       booth_term = -(mx << 1);
      3'h5, 3'h6: booth_term = -mx;
      default:    booth_term = '0;
    endcase
  endfunction

  function automatic logic [W-1:0] shift_one(input logic [W-1:0] v, input fpau_pkg::fpau_shift_t m);
    unique case (m)
      fpau_pkg::FPAU_SH_LEFT_OPEN:    shift_one = {v[W-2:0], 1'b0};
      fpau_pkg::FPAU_SH_LEFT_CLOSED:  shift_one = {v[W-2:0], v[W-1]};
      fpau_pkg::FPAU_SH_RIGHT_OPEN:   shift_one = {v[W-1], v[W-1:1]};
      fpau_pkg::FPAU_SH_RIGHT_CLOSED: shift_one = {v[0], v[W-1:1]};
    endcase
  endfunction

  // ========================================
  // multiply step: radix-4 recoding of two low mq bits plus carried bit
  logic          mbit_q;
  logic [W+1:0]  pp_sum;
  logic [W+1:0]  pp_ext;
  always_comb begin
    pp_ext = {{2{a_q[W-1]}}, a_q};
    pp_sum = pp_ext + booth_term({q_q[1:0], mbit_q}, d_q); // see RULE7
  end

  // divide step: restoring on magnitudes, signs fixed at the end
  logic [W:0] div_diff;
  always_comb begin
    div_diff = {1'b0, a_q[W-2:0], q_q[W-1]} - {1'b0, (d_q[W-1] ? -d_q : d_q)};
  end

  // ========================================
  // sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= fpau_pkg::FPAU_ST_IDLE;
      op_q    <= fpau_pkg::FPAU_OP_LOAD_A;
      mode_q  <= fpau_pkg::FPAU_SH_LEFT_OPEN;
    end else begin
      unique case (state_q)
        fpau_pkg::FPAU_ST_IDLE: if (start) begin
          op_q    <= op;
          mode_q  <= shift_mode;
          state_q <= fpau_pkg::FPAU_ST_STEP;
        end
        fpau_pkg::FPAU_ST_STEP: if ((op_q != fpau_pkg::FPAU_OP_SCALE && n_q == '0) ||
            op_q inside {fpau_pkg::FPAU_OP_LOAD_A,
            fpau_pkg::FPAU_OP_LOAD_Q, fpau_pkg::FPAU_OP_ADD, fpau_pkg::FPAU_OP_SUB,
            fpau_pkg::FPAU_OP_AND, fpau_pkg::FPAU_OP_OR, fpau_pkg::FPAU_OP_XOR,
            fpau_pkg::FPAU_OP_INDEX, fpau_pkg::FPAU_OP_STORE_A, fpau_pkg::FPAU_OP_STORE_Q,
            fpau_pkg::FPAU_OP_LOAD_IR} ||
            (op_q == fpau_pkg::FPAU_OP_SCALE &&
             (a_q[W-1] != a_q[W-2] || n_q == `FPAU_SCALE_MAX))) begin
          state_q <= fpau_pkg::FPAU_ST_WAIT; // see RULE17
        end
        fpau_pkg::FPAU_ST_WAIT: if (pace_exp) begin
          state_q <= fpau_pkg::FPAU_ST_DONE; // see RULE16
        end
        fpau_pkg::FPAU_ST_DONE: state_q <= fpau_pkg::FPAU_ST_IDLE;
      endcase
    end
  end

  // pacing: total time from start, fetch time included in the figure
  always_comb begin
    unique case (op)
      fpau_pkg::FPAU_OP_MUL: pace_cycles = 8'(`FPAU_MUL_CYC - 2);
      fpau_pkg::FPAU_OP_DIV: pace_cycles = 8'(`FPAU_DIV_CYC - 2);
      default:               pace_cycles = 8'(`FPAU_ADD_CYC - 2);
    endcase
  end
  assign pace_load = start && state_q == fpau_pkg::FPAU_ST_IDLE;

  fpau_pace #(.CNT_W(8)) u_pace (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (pace_load),
    .cycles  (pace_cycles),
    .expired (pace_exp)
  );

  // ========================================
  // transient and instruction registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      d_q <= `FPAU_RST_WORD;
    end else if (pace_load) begin
      d_q <= mem_rdata; // see RULE11 see RULE12
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_q <= `FPAU_RST_WORD;
    end else if (state_q == fpau_pkg::FPAU_ST_STEP && op_q == fpau_pkg::FPAU_OP_LOAD_IR) begin
      ir_q <= d_q; // see RULE15
    end
  end

  // index modifier in the transient register is added to the address field
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ea_q <= '0;
    end else if (state_q == fpau_pkg::FPAU_ST_STEP && op_q == fpau_pkg::FPAU_OP_INDEX) begin
      ea_q <= {1'b0, ir_q[`FPAU_IR_ADDR_MSB:`FPAU_IR_ADDR_LSB]} + {1'b0, d_q[13:0]}; // see RULE11 see RULE15
    end
  end

  // ========================================
  // shift counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      n_q <= `FPAU_RST_CNT;
    end else if (pace_load) begin
      unique case (op)
        fpau_pkg::FPAU_OP_MUL:   n_q <= `FPAU_MUL_STEPS; // see RULE13 see RULE17
        fpau_pkg::FPAU_OP_DIV:   n_q <= `FPAU_DIV_STEPS;
        fpau_pkg::FPAU_OP_SCALE: n_q <= `FPAU_RST_CNT;
        default:                 n_q <= shift_count;
      endcase
    end else if (state_q == fpau_pkg::FPAU_ST_STEP) begin
      if (op_q == fpau_pkg::FPAU_OP_SCALE) begin
        if (a_q[W-1] == a_q[W-2] && n_q != `FPAU_SCALE_MAX) begin
          n_q <= n_q + 1'b1; // see RULE14
        end
      end else if (n_q != '0) begin
        n_q <= n_q - 1'b1; // see RULE17
      end
    end
  end

  // ========================================
  // accumulator and mq
  logic step_en;
  assign step_en = state_q == fpau_pkg::FPAU_ST_STEP;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      a_q       <= `FPAU_RST_WORD;
      q_q       <= `FPAU_RST_WORD;
      mbit_q    <= 1'b0;
      rem_neg_q <= 1'b0;
    end else if (pace_load && op == fpau_pkg::FPAU_OP_MUL) begin
      a_q    <= `FPAU_RST_WORD; // see RULE2
      mbit_q <= 1'b0;
    end else if (pace_load && op == fpau_pkg::FPAU_OP_DIV) begin
      rem_neg_q <= a_q[W-1];
      // take magnitudes of the 48-bit dividend
      {a_q, q_q} <= a_q[W-1] ? -{a_q, q_q} : {a_q, q_q}; // see RULE9
    end else if (step_en) begin
      unique case (op_q)
        fpau_pkg::FPAU_OP_LOAD_A: a_q <= d_q;
        fpau_pkg::FPAU_OP_LOAD_Q: q_q <= d_q;
        fpau_pkg::FPAU_OP_ADD:    a_q <= a_q + d_q; // see RULE1 see RULE3
        fpau_pkg::FPAU_OP_SUB:    a_q <= a_q - d_q; // see RULE3
        fpau_pkg::FPAU_OP_AND:    a_q <= a_q & d_q; // see RULE5
        fpau_pkg::FPAU_OP_OR:     a_q <= a_q | d_q;
        fpau_pkg::FPAU_OP_XOR:    a_q <= a_q ^ d_q;
        fpau_pkg::FPAU_OP_MUL: if (n_q != '0) begin
          // arithmetic shift of the new partial product by two into mq
          {a_q, q_q} <= {pp_sum[W+1:2], pp_sum[1:0], q_q[W-1:2]}; // see RULE4 see RULE7 see RULE8
          mbit_q     <= q_q[1];
        end
        fpau_pkg::FPAU_OP_DIV: begin
          if (n_q != '0) begin
            if (!div_diff[W]) begin
              {a_q, q_q} <= {div_diff[W-1:0], q_q[W-2:0], 1'b1}; // see RULE9
            end else begin
              {a_q, q_q} <= {a_q[W-2:0], q_q[W-1], q_q[W-2:0], 1'b0};
            end
          end else begin
            // fix signs: quotient sign lands in mq msb, remainder follows dividend
            q_q <= (rem_neg_q ^ d_q[W-1]) ? -q_q : q_q; // see RULE9
            a_q <= rem_neg_q ? -a_q : a_q; // see RULE5
          end
        end
        fpau_pkg::FPAU_OP_SHIFT_A: if (n_q != '0) begin
          a_q <= shift_one(a_q, mode_q); // see RULE6
        end
        fpau_pkg::FPAU_OP_SHIFT_AQ: if (n_q != '0) begin
          unique case (mode_q)
            fpau_pkg::FPAU_SH_LEFT_OPEN:    {a_q, q_q} <= {a_q[W-2:0], q_q, 1'b0}; // see RULE10
            fpau_pkg::FPAU_SH_LEFT_CLOSED:  {a_q, q_q} <= {a_q[W-2:0], q_q, a_q[W-1]};
            fpau_pkg::FPAU_SH_RIGHT_OPEN:   {a_q, q_q} <= {a_q[W-1], a_q, q_q[W-1:1]};
            fpau_pkg::FPAU_SH_RIGHT_CLOSED: {a_q, q_q} <= {q_q[0], a_q, q_q[W-1:1]};
          endcase
        end
        fpau_pkg::FPAU_OP_SCALE: if (a_q[W-1] == a_q[W-2] && n_q != `FPAU_SCALE_MAX) begin
          a_q <= {a_q[W-2:0], 1'b0}; // see RULE14
        end
        default: ;
      endcase
    end
  end

  // ========================================
  // memory write path: accumulator, mq or shift counter straight into wdata_q
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_we_q <= 1'b0;
      wdata_q  <= `FPAU_RST_WORD;
    end else begin
      mem_we_q <= 1'b0;
      if (state_q == fpau_pkg::FPAU_ST_WAIT && pace_exp) begin
        unique case (op_q)
          fpau_pkg::FPAU_OP_SCALE: begin
            mem_we_q <= 1'b1;
            wdata_q  <= {{(W-NW){1'b0}}, n_q}; // see RULE14
          end
          fpau_pkg::FPAU_OP_STORE_A: begin
            mem_we_q <= 1'b1;
            wdata_q  <= a_q; // see RULE12
          end
          fpau_pkg::FPAU_OP_STORE_Q: begin
            mem_we_q <= 1'b1;
            wdata_q  <= q_q;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= state_q == fpau_pkg::FPAU_ST_WAIT && pace_exp;
    end
  end

  // ========================================
  // outputs
  assign busy       = state_q != fpau_pkg::FPAU_ST_IDLE;
  assign done       = done_q;
  assign mem_we     = mem_we_q;
  assign mem_wdata  = wdata_q;
  assign acc        = a_q;
  assign mq         = q_q;
  assign shift_cnt  = n_q;
  assign func_code  = ir_q[`FPAU_IR_F_MSB:`FPAU_IR_F_LSB]; // see RULE15
  assign desig      = ir_q[17:14];
  assign eff_addr   = ea_q[13:0];
  assign addr_carry = ea_q[14];

  // ========================================
  // checks
  add_result_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
    step_en && op_q == fpau_pkg::FPAU_OP_ADD |=> a_q == $past(a_q) + $past(d_q))
    else $error("add result wrong");
  sub_result_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE3
    step_en && op_q == fpau_pkg::FPAU_OP_SUB |=> a_q == $past(a_q) - $past(d_q))
    else $error("sub result wrong");
  mul_load_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE13
    pace_load && op == fpau_pkg::FPAU_OP_MUL |=> n_q == `FPAU_MUL_STEPS)
    else $error("multiply count not loaded");
  div_load_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE13
    pace_load && op == fpau_pkg::FPAU_OP_DIV |=> n_q == `FPAU_DIV_STEPS)
    else $error("divide count not loaded");
  add_time_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
    pace_load && op == fpau_pkg::FPAU_OP_ADD |-> ##40 done)
    else $error("add time wrong");
  mul_time_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
    pace_load && op == fpau_pkg::FPAU_OP_MUL |-> ##120 done)
    else $error("multiply time wrong");
  div_time_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE16
    pace_load && op == fpau_pkg::FPAU_OP_DIV |-> ##220 done)
    else $error("divide time wrong");
  count_down_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE17
    step_en && op_q == fpau_pkg::FPAU_OP_SHIFT_A && n_q != '0 |=> n_q == $past(n_q) - 1'b1)
    else $error("shift count not decremented");
  scale_store_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE14
    mem_we && op_q == fpau_pkg::FPAU_OP_SCALE |-> mem_wdata[NW-1:0] == n_q)
    else $error("scale count not stored");
  ir_load_a: assert property (@(posedge clk) disable iff (sys_rst) // see RULE15
    step_en && op_q == fpau_pkg::FPAU_OP_LOAD_IR |=> ir_q == $past(d_q))
    else $error("instruction register not loaded");

endmodule

// ---- rtl/fpau_consts.svh ----
// constant definitions for the fixed-point arithmetic unit
`ifndef FPAU_CONSTS_SVH
`define FPAU_CONSTS_SVH

// ========================================
// widths
`define FPAU_WORD_W      24
`define FPAU_CNT_W       6

// ========================================
// step counts loaded into the shift counter, and the scale count limit
`define FPAU_MUL_STEPS   6'h0c
`define FPAU_DIV_STEPS   6'h18
`define FPAU_SCALE_MAX   6'h17

// ========================================
// instruction register field positions
`define FPAU_IR_ADDR_LSB 0
`define FPAU_IR_ADDR_MSB 13
`define FPAU_IR_F_LSB    18
`define FPAU_IR_F_MSB    22

// ========================================
// timing, in nanoseconds, and clock period
`define FPAU_CLK_NS      100
`define FPAU_ADD_NS      4000
`define FPAU_MUL_NS      12000
`define FPAU_DIV_NS      22000
`define FPAU_ADD_CYC     (`FPAU_ADD_NS / `FPAU_CLK_NS)
`define FPAU_MUL_CYC     (`FPAU_MUL_NS / `FPAU_CLK_NS)
`define FPAU_DIV_CYC     (`FPAU_DIV_NS / `FPAU_CLK_NS)

// ========================================
// reset values
`define FPAU_RST_WORD    24'h000000
`define FPAU_RST_CNT     6'h00

`endif

// ---- rtl/fpau_pkg.sv ----
// type definitions for the fixed-point arithmetic unit
package fpau_pkg;

  typedef enum logic [3:0] {
    FPAU_OP_LOAD_A,
    FPAU_OP_LOAD_Q,
    FPAU_OP_ADD,
    FPAU_OP_SUB,
    FPAU_OP_MUL,
    FPAU_OP_DIV,
    FPAU_OP_AND,
    FPAU_OP_OR,
    FPAU_OP_XOR,
    FPAU_OP_SHIFT_A,
    FPAU_OP_SHIFT_AQ,
    FPAU_OP_SCALE,
    FPAU_OP_INDEX,
    FPAU_OP_STORE_A,
    FPAU_OP_STORE_Q,
    FPAU_OP_LOAD_IR
  } fpau_op_t;

  typedef enum logic [1:0] {
    FPAU_SH_LEFT_OPEN,
    FPAU_SH_LEFT_CLOSED,
    FPAU_SH_RIGHT_OPEN,
    FPAU_SH_RIGHT_CLOSED
  } fpau_shift_t;

  typedef enum logic [2:0] {
    FPAU_ST_IDLE,
    FPAU_ST_WAIT,
    FPAU_ST_STEP,
    FPAU_ST_DONE
  } fpau_state_t;

endpackage

// ---- rtl/fpau_pace.sv ----
// cycle pacing counter that stretches an operation to its documented time
`include "fpau_consts.svh"

module fpau_pace #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  expired
);

  logic [CNT_W-1:0] cnt_q;

  // counts down from the requested total; expired is high when idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= cycles;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0) && !load;

endmodule

// ---- tb/fpau_mem_model.sv ----
// memory-side partner model: serves operands and records write-backs
`include "fpau_consts.svh"

module fpau_mem_model (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    start,
  input  wire logic                    busy,
  input  wire logic [`FPAU_WORD_W-1:0] word,
  input  wire logic                    mem_we,
  input  wire logic [`FPAU_WORD_W-1:0] mem_wdata,
  output logic      [`FPAU_WORD_W-1:0] mem_rdata,
  output logic      [`FPAU_WORD_W-1:0] wr_data,
  output logic      [7:0]              wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  // ========================================
  // operand path
  // the word is only valid while a request is taken; otherwise the inverse shows,
  // so a late or early sample by the unit cannot pass by luck
  always_comb begin
    mem_rdata = (start && !busy) ? word : ~word;
  end

  // ========================================
  // write-back capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_cnt  <= 8'h00;
      wr_data <= 24'h000000;
    end else if (mem_we) begin
      wr_data <= mem_wdata;
      wr_cnt  <= wr_cnt + 8'h01;
    end
  end
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the fixed-point arithmetic unit
`include "fpau_consts.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = `FPAU_WORD_W;

  logic                  clk;
  logic                  sys_rst;
  logic                  start;
  logic                  busy;
  logic                  done;
  logic                  mem_we;
  logic                  addr_carry;
  logic                  poke;
  fpau_pkg::fpau_op_t    op;
  fpau_pkg::fpau_shift_t shift_mode;
  logic [5:0]            shift_count;
  logic [5:0]            shift_cnt;
  logic [W-1:0]          word;
  logic [W-1:0]          mem_rdata;
  logic [W-1:0]          mem_wdata;
  logic [W-1:0]          acc;
  logic [W-1:0]          mq;
  logic [W-1:0]          wr_data;
  logic [4:0]            func_code;
  logic [3:0]            desig;
  logic [13:0]           eff_addr;
  logic [7:0]            wr_cnt;
  int                    fail_count;
  int                    checks;
  int                    lat;

  fpau_core i_dut (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .start      (start),
    .op         (op),
    .shift_mode (shift_mode),
    .shift_count(shift_count),
    .mem_rdata  (mem_rdata),
    .busy       (busy),
    .done       (done),
    .mem_we     (mem_we),
    .mem_wdata  (mem_wdata),
    .acc        (acc),
    .mq         (mq),
    .shift_cnt  (shift_cnt),
    .func_code  (func_code),
    .desig      (desig),
    .eff_addr   (eff_addr),
    .addr_carry (addr_carry)
  );

  fpau_mem_model i_mem (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .start    (start),
    .busy     (busy),
    .word     (word),
    .mem_we   (mem_we),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .wr_data  (wr_data),
    .wr_cnt   (wr_cnt)
  );

  // ========================================
  // shared tasks
  task automatic chk(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // one operation, from request to the cycle after done; poke fires a refused request
  task automatic run(input fpau_pkg::fpau_op_t o, input logic [W-1:0] d, input int exp_lat,
                     input fpau_pkg::fpau_shift_t m = fpau_pkg::FPAU_SH_LEFT_OPEN,
                     input logic [5:0] c = 6'h00);
    @(negedge clk);
    start = 1'b1;
    op = o;
    word = d;
    shift_mode = m;
    shift_count = c;
    @(negedge clk);
    start = 1'b0;
    chk("busy", 24'h000001, {23'h0, busy});
    lat = 0;
    while (done !== 1'b1 && lat < 400) begin
      if (poke) begin
        start = (lat == 5);
        op = fpau_pkg::FPAU_OP_LOAD_A;
      end
      @(negedge clk);
      lat++;
    end
    chk("latency", W'(exp_lat), W'(lat));
    @(negedge clk);
    chk("busy", 24'h000000, {23'h0, busy});
  endtask

  // ========================================
  // scenarios
  task automatic t_reset();
    chk("acc", 24'h000000, acc);
    chk("mq", 24'h000000, mq);
    chk("shift_cnt", 24'h000000, W'(shift_cnt));
  endtask

  task automatic t_addsub();
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000005, 39);
    run(fpau_pkg::FPAU_OP_ADD, 24'hfffffd, 39);
    chk("acc", 24'h000002, acc);
    run(fpau_pkg::FPAU_OP_SUB, 24'h000007, 39);
    chk("acc", 24'hfffffb, acc);
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h7fffff, 39);
    run(fpau_pkg::FPAU_OP_ADD, 24'h000001, 39);
    chk("acc", 24'h800000, acc);
  endtask

  task automatic t_logic();
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'hf0f0f0, 39);
    run(fpau_pkg::FPAU_OP_AND, 24'h0ff0ff, 39);
    chk("acc", 24'h00f0f0, acc);
    run(fpau_pkg::FPAU_OP_OR, 24'h0f0000, 39);
    chk("acc", 24'h0ff0f0, acc);
    run(fpau_pkg::FPAU_OP_XOR, 24'hffffff, 39);
    chk("acc", 24'hf00f0f, acc);
  endtask

  task automatic t_mul();
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'hfffffd, 39);
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h123456, 39);
    run(fpau_pkg::FPAU_OP_MUL, 24'h000005, 119);
    chk("acc", 24'hffffff, acc);
    chk("mq", 24'hfffff1, mq);
    chk("shift_cnt", 24'h000000, W'(shift_cnt));
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'h000004, 39);
    run(fpau_pkg::FPAU_OP_MUL, 24'h400000, 119);
    chk("acc", 24'h000001, acc);
    chk("mq", 24'h000000, mq);
  endtask

  task automatic t_div();
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000000, 39);
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'h000064, 39);
    run(fpau_pkg::FPAU_OP_DIV, 24'h000007, 219);
    chk("mq", 24'h00000e, mq);
    chk("acc", 24'h000002, acc);
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'hffffff, 39);
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'hffff9c, 39);
    run(fpau_pkg::FPAU_OP_DIV, 24'h000007, 219);
    chk("mq", 24'hfffff2, mq);
    chk("acc", 24'hfffffe, acc);
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000000, 39);
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'h000064, 39);
    run(fpau_pkg::FPAU_OP_DIV, 24'hfffff9, 219);
    chk("mq", 24'hfffff2, mq);
    chk("acc", 24'h000002, acc);
  endtask

  task automatic t_shift();
    logic [W-1:0] exp_tab [4];
    exp_tab = '{24'h000010, 24'h000018, 24'hf80000, 24'h180000};
    for (int i = 0; i < 4; i++) begin
      run(fpau_pkg::FPAU_OP_LOAD_A, 24'h800001, 39);
      run(fpau_pkg::FPAU_OP_SHIFT_A, 24'h000000, 39, fpau_pkg::fpau_shift_t'(i[1:0]), 6'h04);
      chk("acc", exp_tab[i], acc);
      chk("shift_cnt", 24'h000000, W'(shift_cnt));
    end
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000000, 39);
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'h800000, 39);
    run(fpau_pkg::FPAU_OP_SHIFT_AQ, 24'h000000, 39, fpau_pkg::FPAU_SH_LEFT_OPEN, 6'h01);
    chk("acc", 24'h000001, acc);
    chk("mq", 24'h000000, mq);
    run(fpau_pkg::FPAU_OP_SHIFT_AQ, 24'h000000, 39, fpau_pkg::FPAU_SH_RIGHT_OPEN, 6'h01);
    chk("acc", 24'h000000, acc);
    chk("mq", 24'h800000, mq);
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'h000001, 39);
    run(fpau_pkg::FPAU_OP_SHIFT_AQ, 24'h000000, 39, fpau_pkg::FPAU_SH_RIGHT_CLOSED, 6'h01);
    chk("acc", 24'h800000, acc);
    chk("mq", 24'h000000, mq);
    run(fpau_pkg::FPAU_OP_SHIFT_AQ, 24'h000000, 39, fpau_pkg::FPAU_SH_LEFT_CLOSED, 6'h01);
    chk("acc", 24'h000000, acc);
    chk("mq", 24'h000001, mq);
  endtask

  task automatic t_scale();
    logic [7:0] n0;
    n0 = wr_cnt;
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000003, 39);
    run(fpau_pkg::FPAU_OP_SCALE, 24'h000000, 39);
    chk("acc", 24'h600000, acc);
    chk("shift_cnt", 24'h000015, W'(shift_cnt));
    chk("wr_data", 24'h000015, wr_data);
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000000, 39);
    run(fpau_pkg::FPAU_OP_SCALE, 24'h000000, 39);
    chk("shift_cnt", W'(`FPAU_SCALE_MAX), W'(shift_cnt));
    chk("wr_data", W'(`FPAU_SCALE_MAX), wr_data);
    chk("wr_cnt", W'(n0 + 8'h02), W'(wr_cnt));
  endtask

  task automatic t_xfer();
    run(fpau_pkg::FPAU_OP_LOAD_IR, {1'b0, 5'h15, 4'ha, 14'h3ffe}, 39);
    chk("func_code", 24'h000015, W'(func_code));
    chk("desig", 24'h00000a, W'(desig));
    run(fpau_pkg::FPAU_OP_INDEX, 24'h000005, 39);
    chk("eff_addr", 24'h004003, {9'h0, addr_carry, eff_addr});
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h0a5a5a, 39);
    run(fpau_pkg::FPAU_OP_STORE_A, 24'h000000, 39);
    chk("wr_data", 24'h0a5a5a, wr_data);
    run(fpau_pkg::FPAU_OP_LOAD_Q, 24'h5a5a5a, 39);
    run(fpau_pkg::FPAU_OP_STORE_Q, 24'h000000, 39);
    chk("wr_data", 24'h5a5a5a, wr_data);
    chk("acc", 24'h0a5a5a, acc);
  endtask

  // a request made while busy must leave no trace
  task automatic t_refuse();
    run(fpau_pkg::FPAU_OP_LOAD_A, 24'h000010, 39);
    poke = 1'b1;
    run(fpau_pkg::FPAU_OP_ADD, 24'h000001, 39);
    poke = 1'b0;
    chk("acc", 24'h000011, acc);
  endtask

  // ========================================
  // clock, reset, sequence, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    poke = 1'b0;
    op = fpau_pkg::FPAU_OP_LOAD_A;
    shift_mode = fpau_pkg::FPAU_SH_LEFT_OPEN;
    shift_count = 6'h00;
    word = 24'h000000;
    fail_count = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_addsub();
    t_logic();
    t_mul();
    t_div();
    t_shift();
    t_scale();
    t_xfer();
    t_refuse();
    close_out();
  end

  // the sequence needs about 3000 cycles; allow several times that
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
endmodule
